// [slhs_top.sv]
/*
 serial lane health status registers for lanes 1 to 4, an AHB-Lite slave with interrupt.
 assumes the lane receiver runs on mclk and drives counts and locks for every link;
 the only master drives single word transfers and hready is this slave's hreadyout.
*/
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "slhs_regs.svh"
module slhs_top
   import slhs_pkg::*;
#(
   parameter int NUM_LINKS = `SLHS_NUM_LINKS,
   parameter int NUM_LANES = `SLHS_NUM_LANES
)(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // ahb-lite slave
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic          hready,
   input  wire logic [31:0]   hwdata,
   output logic      [31:0]   hrdata,
   output logic               hreadyout,
   output logic               hresp,
   // lane receiver, indexed by link then lane (lane 1 at index 0)
   input  wire slhs_lane_rx_t laneRx [NUM_LINKS][NUM_LANES],
   // interrupt
   output logic               irq
);

   logic [7:0]    pageFf;
   logic [7:0]    thresholdFf;
   logic [7:0]    intStatusFf;
   logic [7:0]    intMaskFf;
   logic [7:0]    nxt_intStatus;
   logic [7:0]    laneEvent;
   logic [7:0]    rdMux;
   slhs_health_t  healthFf [NUM_LANES];
   slhs_health_t  nxt_health [NUM_LANES];
   slhs_lane_rx_t selRx [NUM_LANES];
   logic          dataPhaseFf;
   logic          writeFf;
   logic          mappedFf;
   logic [11:0]   addrIdxFf;
   logic [31:0]   hrdataFf;
   logic          hreadyoutFf;
   logic          irqFf;
   logic          addrAccept;
   logic          wrStrobe;
   logic          rdStrobe;

   assign hrdata    = hrdataFf;
   assign hreadyout = hreadyoutFf;
   assign hresp     = 1'b0;
   assign irq       = irqFf;

   // flags of one lane from its counts and locks
   function automatic slhs_health_t health_of(input slhs_lane_rx_t x, input logic [7:0] th);
      slhs_health_t h;
      h.disparityErrorFlag   = (x.disparityCount >= th); // RULE1 RULE12
      h.invalidSymbolFlag    = (x.invalidCount >= th);   // RULE2 RULE12
      h.strayControlCharFlag = (x.strayCount >= th);     // RULE3 RULE12
      h.laneDeskewOk         = x.laneDeskewOk;           // RULE4
      h.initialAlignmentOk   = x.initialAlignmentOk;     // RULE5
      h.frameSumMatch        = x.frameSumMatch;          // RULE6
      h.frameLock            = x.frameLock;              // RULE7
      h.codeGroupLock        = x.codeGroupLock;          // RULE8
      return h;
   endfunction

   // an out of range page selects no link and reads as all flags clear, except that a zero threshold sets the three error flags
   always_comb
   begin
      for (int l = 0; l < NUM_LANES; l++)
      begin
         selRx[l] = '0;
         for (int k = 0; k < NUM_LINKS; k++)
         begin
            if (pageFf == 8'(k))
            begin
               selRx[l] = laneRx[k][l]; // RULE9
            end
         end
         nxt_health[l] = health_of(selRx[l], thresholdFf);
      end
   end

   // flags follow the receiver every cycle, independent of bus traffic
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int l = 0; l < NUM_LANES; l++)
         begin
            healthFf[l] <= `SLHS_HEALTH_RST; // RULE11
         end
      end
      else
      begin
         for (int l = 0; l < NUM_LANES; l++)
         begin
            healthFf[l] <= nxt_health[l]; // RULE13
         end
      end
   end

   // bus: one wait state, so a read always sees every earlier write
   assign addrAccept = hsel & htrans[1] & hready;
   assign wrStrobe   = dataPhaseFf & writeFf & mappedFf;
   assign rdStrobe   = dataPhaseFf & ~writeFf & mappedFf;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dataPhaseFf <= 1'b0;
         writeFf     <= 1'b0;
         mappedFf    <= 1'b0;
         addrIdxFf   <= 12'h000;
         hreadyoutFf <= 1'b1;
      end
      else if (addrAccept)
      begin
         dataPhaseFf <= 1'b1;
         writeFf     <= hwrite;
         mappedFf    <= (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);
         addrIdxFf   <= haddr[13:2];
         hreadyoutFf <= 1'b0;
      end
      else if (dataPhaseFf)
      begin
         dataPhaseFf <= 1'b0;
         hreadyoutFf <= 1'b1;
      end
   end

   always_comb
   begin
      rdMux = 8'h00;
      unique case (addrIdxFf)
         `SLHS_IDX_LANE1:     rdMux = healthFf[0];
         `SLHS_IDX_LANE2:     rdMux = healthFf[1]; // RULE10
         `SLHS_IDX_LANE3:     rdMux = healthFf[2]; // RULE10
         `SLHS_IDX_LANE4:     rdMux = healthFf[3]; // RULE10
         `SLHS_IDX_LINK_PAGE: rdMux = pageFf;
         `SLHS_IDX_THRESHOLD: rdMux = thresholdFf;
         `SLHS_IDX_INT_STAT:  rdMux = intStatusFf;
         `SLHS_IDX_INT_MASK:  rdMux = intMaskFf;
         default:             rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         hrdataFf <= 32'h00000000;
      end
      else if (dataPhaseFf && !writeFf)
      begin
         hrdataFf <= rdStrobe ? {24'h000000, rdMux} : 32'h00000000;
      end
   end

   // control registers; lane health indices ignore writes
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pageFf      <= `SLHS_PAGE_RST;
         thresholdFf <= `SLHS_THRESHOLD_RST;
         intMaskFf   <= `SLHS_MASK_RST;
      end
      else if (wrStrobe)
      begin
         if (addrIdxFf == `SLHS_IDX_LINK_PAGE)
         begin
            pageFf <= hwdata[7:0]; // RULE9
         end
         if (addrIdxFf == `SLHS_IDX_THRESHOLD)
         begin
            thresholdFf <= hwdata[7:0]; // RULE12
         end
         if (addrIdxFf == `SLHS_IDX_INT_MASK)
         begin
            intMaskFf <= hwdata[7:0];
         end
      end
   end

   // events: low nibble an error flag rising, high nibble a lock falling.
   // a page change may raise events too, since the flags now describe another link.
   always_comb
   begin
      laneEvent = 8'h00;
      for (int l = 0; l < NUM_LANES; l++)
      begin
         laneEvent[l] = (nxt_health[l].disparityErrorFlag & ~healthFf[l].disparityErrorFlag)
                      | (nxt_health[l].invalidSymbolFlag & ~healthFf[l].invalidSymbolFlag)
                      | (nxt_health[l].strayControlCharFlag
                         & ~healthFf[l].strayControlCharFlag);
         laneEvent[l + 4] = (healthFf[l].codeGroupLock & ~nxt_health[l].codeGroupLock)
                          | (healthFf[l].frameLock & ~nxt_health[l].frameLock);
      end
   end

   // a new event wins over a clear in the same cycle
   always_comb
   begin
      nxt_intStatus = intStatusFf;
      if (wrStrobe && (addrIdxFf == `SLHS_IDX_INT_STAT))
      begin
         nxt_intStatus = intStatusFf & ~hwdata[7:0];
      end
      nxt_intStatus = nxt_intStatus | laneEvent;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         intStatusFf <= 8'h00;
      end
      else
      begin
         intStatusFf <= nxt_intStatus;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         irqFf <= 1'b0;
      end
      else
      begin
         irqFf <= |(intStatusFf & intMaskFf);
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   for (genvar l = 0; l < NUM_LANES; l++)
   begin : g_chk
      a_disp_flag: assert property ( // RULE1
         healthFf[l].disparityErrorFlag ==
         ($past(selRx[l].disparityCount) >= $past(thresholdFf)))
         else $error("disparity flag wrong");
      a_invalid_flag: assert property ( // RULE2
         healthFf[l].invalidSymbolFlag ==
         ($past(selRx[l].invalidCount) >= $past(thresholdFf)))
         else $error("invalid symbol flag wrong");
      a_stray_flag: assert property ( // RULE3
         ($past(pageFf) == 8'h00 && $past(laneRx[0][l].strayCount) == $past(thresholdFf))
         |-> healthFf[l].strayControlCharFlag)
         else $error("stray flag not set at threshold");
      a_deskew_flag: assert property ( // RULE4
         $past(pageFf) == 8'h00 |->
         healthFf[l].laneDeskewOk == $past(laneRx[0][l].laneDeskewOk))
         else $error("deskew flag wrong");
      a_align_flag: assert property ( // RULE5
         $past(pageFf) == 8'h01 |->
         healthFf[l].initialAlignmentOk == $past(laneRx[1][l].initialAlignmentOk))
         else $error("alignment flag wrong");
      a_sum_flag: assert property ( // RULE6
         $past(pageFf) == 8'h00 |->
         healthFf[l].frameSumMatch == $past(laneRx[0][l].frameSumMatch))
         else $error("checksum flag wrong");
      a_frame_flag: assert property ( // RULE7
         $past(pageFf) == 8'h01 |->
         healthFf[l].frameLock == $past(laneRx[1][l].frameLock))
         else $error("frame lock flag wrong");
      a_cg_flag: assert property ( // RULE8
         $past(pageFf) == 8'h00 |->
         healthFf[l].codeGroupLock == $past(laneRx[0][l].codeGroupLock))
         else $error("code group flag wrong");
      // the same flags while the other link is selected
      a_deskew_other: assert property ( // RULE4
         $past(pageFf) == 8'h01 |->
         healthFf[l].laneDeskewOk == $past(laneRx[1][l].laneDeskewOk))
         else $error("deskew flag wrong on page one");
      a_align_other: assert property ( // RULE5
         $past(pageFf) == 8'h00 |->
         healthFf[l].initialAlignmentOk == $past(laneRx[0][l].initialAlignmentOk))
         else $error("alignment flag wrong on page zero");
      a_sum_other: assert property ( // RULE6
         $past(pageFf) == 8'h01 |->
         healthFf[l].frameSumMatch == $past(laneRx[1][l].frameSumMatch))
         else $error("checksum flag wrong on page one");
      a_frame_other: assert property ( // RULE7
         $past(pageFf) == 8'h00 |->
         healthFf[l].frameLock == $past(laneRx[0][l].frameLock))
         else $error("frame lock flag wrong on page zero");
      a_cg_other: assert property ( // RULE8
         $past(pageFf) == 8'h01 |->
         healthFf[l].codeGroupLock == $past(laneRx[1][l].codeGroupLock))
         else $error("code group flag wrong on page one");
      a_page_range: assert property ( // RULE9
         $past(pageFf) >= 8'(NUM_LINKS) |-> healthFf[l] == 8'h00)
         else $error("unselected page shows flags");
      a_lane_read: assert property ( // RULE10
         (rdStrobe && addrIdxFf == (`SLHS_IDX_LANE1 + 12'(l))) |=>
         hrdataFf == {24'h000000, $past(healthFf[l])})
         else $error("lane read data wrong");
      a_reset_zero: assert property (disable iff (1'b0) // RULE11
         rst |-> healthFf[l] == 8'h00)
         else $error("flags not zero in reset");
   end

   a_read_keeps: assert property ( // RULE13
      (dataPhaseFf && !writeFf) |=> (intStatusFf & $past(intStatusFf)) == $past(intStatusFf))
      else $error("read changed status");
   a_bus_wait: assert property (
      addrAccept |=> !hreadyoutFf ##1 hreadyoutFf)
      else $error("wait state wrong");
   a_irq_level: assert property (
      irqFf == $past(|(intStatusFf & intMaskFf)))
      else $error("irq level wrong");

   // writes, sticky status and the bus answer
   a_page_write: assert property ( // RULE9
      (wrStrobe && addrIdxFf == `SLHS_IDX_LINK_PAGE) |=> pageFf == $past(hwdata[7:0]))
      else $error("page write lost");
   a_thresh_write: assert property ( // RULE12
      (wrStrobe && addrIdxFf == `SLHS_IDX_THRESHOLD) |=> thresholdFf == $past(hwdata[7:0]))
      else $error("threshold write lost");
   a_status_hold: assert property (
      !(wrStrobe && addrIdxFf == `SLHS_IDX_INT_STAT)
      |=> (intStatusFf & $past(intStatusFf)) == $past(intStatusFf))
      else $error("status bit lost without clear");
   a_event_set: assert property (
      laneEvent != 8'h00 |=> (intStatusFf & $past(laneEvent)) == $past(laneEvent))
      else $error("event did not set status");
   a_clear_works: assert property (
      (wrStrobe && addrIdxFf == `SLHS_IDX_INT_STAT && laneEvent == 8'h00)
      |=> (intStatusFf & $past(hwdata[7:0])) == 8'h00)
      else $error("status clear ignored");
   a_unmapped_zero: assert property ( // RULE10
      (dataPhaseFf && !writeFf && !mappedFf) |=> hrdataFf == 32'h00000000)
      else $error("unmapped read not zero");
   a_ready_idle: assert property (
      !dataPhaseFf |-> hreadyoutFf)
      else $error("ready low outside data phase");
   a_irq_masked: assert property (
      intMaskFf == 8'h00 |=> !irqFf)
      else $error("irq with all sources masked");

   c_lane_read: cover property (rdStrobe && addrIdxFf == `SLHS_IDX_LANE2 && rdMux != 8'h00);
   c_page_switch: cover property (wrStrobe && addrIdxFf == `SLHS_IDX_LINK_PAGE
      ##1 pageFf == 8'h01);
   c_page_off: cover property (pageFf >= 8'(NUM_LINKS) && rdStrobe);
   c_irq_rise: cover property ($rose(irqFf));
   c_clear_set: cover property (wrStrobe && addrIdxFf == `SLHS_IDX_INT_STAT && laneEvent != 8'h00);

endmodule // slhs_top

// [slhs_regs.svh]
/*
 constants of the serial lane health status block: register indices, reset values, sizes.
 assumes it is included by slhs_top only.
*/
`ifndef SLHS_REGS_SVH
`define SLHS_REGS_SVH
// Function
// RULE1: bit 7 set while the lane's disparity error count is at or above threshold.
// RULE2: bit 6 set while the lane's invalid symbol count is at or above threshold.
// RULE3: bit 5 set while the lane's stray control character count reaches threshold.
// RULE4: bit 4 is one when interlane deskew is achieved, zero when failed.
// RULE5: bit 3 is one while initial lane alignment holds, zero when lost.
// RULE6: bit 2 is one when the computed checksum matches, zero when incorrect.
// RULE7: bit 1 is one while frame alignment holds, zero when lost.
// RULE8: bit 0 is one while code group sync holds, zero when lost.
// RULE9: all flags describe only the link chosen by the link page register.
// RULE10: lanes 2, 3 and 4 sit at indices 0x4B2, 0x4B3, 0x4B4.
// RULE11: status flags are read only and reset to zero.
// RULE12: the three error flags compare against one shared 8-bit threshold, greater or equal.
// RULE13: flags update continuously; reading them changes no flag or count.
`define SLHS_IDX_LANE1     12'h4B1
`define SLHS_IDX_LANE2     12'h4B2
`define SLHS_IDX_LANE3     12'h4B3
`define SLHS_IDX_LANE4     12'h4B4
`define SLHS_IDX_LINK_PAGE 12'h300
`define SLHS_IDX_THRESHOLD 12'h301
`define SLHS_IDX_INT_STAT  12'h302
`define SLHS_IDX_INT_MASK  12'h303
`define SLHS_HEALTH_RST    8'h00
`define SLHS_PAGE_RST      8'h00
`define SLHS_THRESHOLD_RST 8'h01
`define SLHS_MASK_RST      8'h00
`define SLHS_NUM_LANES     4
`define SLHS_NUM_LINKS     2
`endif

// [slhs_pkg.sv]
/*
 types of the serial lane health status block.
 assumes the lane receiver delivers per lane counts and lock levels in lane_rx_t.
*/
package slhs_pkg;
   typedef struct packed {
      logic [7:0] disparityCount;
      logic [7:0] invalidCount;
      logic [7:0] strayCount;
      logic       laneDeskewOk;
      logic       initialAlignmentOk;
      logic       frameSumMatch;
      logic       frameLock;
      logic       codeGroupLock;
   } slhs_lane_rx_t;
   typedef struct packed {
      logic disparityErrorFlag;
      logic invalidSymbolFlag;
      logic strayControlCharFlag;
      logic laneDeskewOk;
      logic initialAlignmentOk;
      logic frameSumMatch;
      logic frameLock;
      logic codeGroupLock;
   } slhs_health_t;
endpackage

// [slhs_rx_model.sv]
/*
 lane receiver model: counts and lock levels for every link and lane.
 assumes the bench loads one lane every two mclk edges through the set port.
*/
`timescale 1ns/1ps
module slhs_rx_model
   import slhs_pkg::*;
#(
   parameter int NUM_LINKS = 2,
   parameter int NUM_LANES = 4
)(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // load port
   input  wire logic          setEn,
   input  wire logic [1:0]    setLink,
   input  wire logic [1:0]    setLane,
   input  wire slhs_lane_rx_t setVal,
   // to the device
   output slhs_lane_rx_t      laneRx [NUM_LINKS][NUM_LANES]
);
   slhs_lane_rx_t laneRx_ff [NUM_LINKS][NUM_LANES];
   // values move only after an edge, as a receiver in the mclk domain would
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         laneRx_ff <= '{default: '0};
      end
      else if (setEn)
      begin
         laneRx_ff[setLink][setLane] <= setVal;
      end
   end
   assign laneRx = laneRx_ff;
endmodule // slhs_rx_model

// [serial_lane_health_status_bench.sv]
/*
 self-checking bench of slhs_top with an ahb-lite master and a reference model.
 assumes slhs_rx_model stands in for the lane receiver; the master waits for hready.
*/
`timescale 1ns/1ps
module serial_lane_health_status_bench;
   import slhs_pkg::*;
   logic          mclk, rst, hsel, hwrite, hreadyout, hresp, irq, setEn;
   logic [31:0]   haddr, hwdata, hrdata, got;
   logic [1:0]    htrans, setLink, setLane;
   slhs_lane_rx_t setVal;
   slhs_lane_rx_t laneRx [2][4];
   slhs_lane_rx_t refRx [2][4];
   int            err_count, checks_done, page, th;

   slhs_rx_model #(.NUM_LINKS(2), .NUM_LANES(4)) rxm (.mclk(mclk), .rst(rst), .setEn(setEn),
      .setLink(setLink), .setLane(setLane), .setVal(setVal), .laneRx(laneRx));
   slhs_top #(.NUM_LINKS(2), .NUM_LANES(4)) dut (.mclk(mclk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .laneRx(laneRx), .irq(irq));

   task automatic chk(logic [31:0] g, logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // one single transfer; hold each phase until hready is seen high
   task automatic xfer(logic wr, logic [31:0] a, logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      @(posedge mclk);
      // no wait count is assumed; only the watchdog ends a hang
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      got = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic rdChk(logic [31:0] a, logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(got, e);
   endtask

   function automatic logic [31:0] expHealth(int ln);
      slhs_lane_rx_t r;
      if (page > 1)
         return 32'h0;
      r = refRx[page][ln];
      return {24'h0, int'(r.disparityCount) >= th, int'(r.invalidCount) >= th,
              int'(r.strayCount) >= th, r.laneDeskewOk, r.initialAlignmentOk,
              r.frameSumMatch, r.frameLock, r.codeGroupLock};
   endfunction

   task automatic readLanes();
      for (int ln = 0; ln < 4; ln++)
         rdChk(32'h12C4 + 4 * ln, expHealth(ln));
   endtask

   task automatic setRx(int lk, int ln, slhs_lane_rx_t v);
      setEn <= 1'b1;
      setLink <= 2'(lk);
      setLane <= 2'(ln);
      setVal <= v;
      refRx[lk][ln] = v;
      @(posedge mclk);
      setEn <= 1'b0;
      @(posedge mclk);
   endtask

   // counts land on the threshold, just below it, or anywhere
   function automatic logic [7:0] pickCnt();
      case ($urandom % 3)
         0: return 8'(th);
         1: return 8'(th - 1);
         default: return 8'($urandom);
      endcase
   endfunction

   task automatic results();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial
   begin
      #(40 * 20000);
      err_count++;
      results();
   end

   initial
   begin
      slhs_lane_rx_t v;
      rst = 1'b1;
      {hsel, hwrite, setEn, htrans, setLink, setLane} = '0;
      {haddr, hwdata, setVal} = '0;
      {err_count, checks_done, page} = '0;
      th = 1;
      refRx = '{default: '0};
      void'($urandom(7));
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      readLanes();
      rdChk(32'h0000_0C04, 32'h01);
      rdChk(32'h0000_0C0C, 32'h00);
      rdChk(32'h0000_0C08, 32'h00);
      xfer(1'b1, 32'h12C8, 32'hFF);
      readLanes();
      rdChk(32'h0000_4000, 32'h0);
      // events: error flag of lane 1 rises, code group lock of lane 2 falls
      v = '0;
      v.disparityCount = 8'h05;
      setRx(0, 0, v);
      v = '0;
      v.codeGroupLock = 1'b1;
      setRx(0, 1, v);
      setRx(0, 1, '0);
      rdChk(32'h0000_0C08, 32'h21);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, 32'h0000_0C0C, 32'h01);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, 32'h0000_0C08, 32'h01);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      rdChk(32'h0000_0C08, 32'h20);
      readLanes();
      for (int it = 0; it < 24; it++)
      begin
         th = $urandom % 256;
         page = $urandom % 3;
         xfer(1'b1, 32'h0000_0C04, 32'(th));
         xfer(1'b1, 32'h0000_0C00, 32'(page));
         rdChk(32'h0000_0C04, 32'(th));
         for (int k = 0; k < 8; k++)
            setRx(k / 4, k % 4, {pickCnt(), pickCnt(), pickCnt(), 5'($urandom)});
         readLanes();
         readLanes();
      end
      results();
   end
endmodule // serial_lane_health_status_bench
